// >>> verilog/lacc_consts.vh
// Function
// RULE_01: Floor is half or quarter of run current
// RULE_02: Software keeps run current at 10 or 20; the testbench drives run current 24
// RULE_03: Decrement once per 32, 8, 2, 1 measurements
// RULE_04: Reduce when load reaches (lower+hyst+1)*32
// RULE_05: Raise scale by 1, 2, 4 or 8
// RULE_06: Raise when load below lower*32
// RULE_07: Lower threshold zero disables adaptation
// RULE_08: Software writes zero to reserved bits
// RULE_09: Sequencer readbacks are read only
// RULE_10: Ten bit microstep index, phase B offset 256
// RULE_11: Duty scale readback shows applied duty sum
// RULE_12: Auto offset bits 7:0, gradient 23:16
// RULE_13: Adapt only when threshold at least step period
// RULE_14: Load measurement refreshed once per fullstep
// RULE_15: Clamp scale between floor and run current
`ifndef LACC_CONSTS_VH
`define LACC_CONSTS_VH

`define LACC_ADDR_W          7
`define LACC_ADDR_VEL_THRS   7'h14
`define LACC_ADDR_LOAD       7'h41
`define LACC_ADDR_CONFIG     7'h42
`define LACC_ADDR_MSTEP      7'h6A
`define LACC_ADDR_CHOP       7'h6C
`define LACC_ADDR_DRVSTAT    7'h6F
`define LACC_ADDR_VPWM       7'h70
`define LACC_ADDR_DUTY       7'h71
`define LACC_ADDR_TUNE       7'h72

`define LACC_CHOP_RESET      32'h13008001
`define LACC_VPWM_RESET      22'h000000
`define LACC_CONFIG_RESET    16'h0000
`define LACC_CONFIG_MASK     16'hEF6F
`define LACC_VPWM_W          22
`define LACC_VEL_W           20

`define LACC_LOWER_LSB       0
`define LACC_UPW_LSB         5
`define LACC_HYST_LSB        8
`define LACC_DNSPD_LSB       13
`define LACC_QFLOOR_BIT      15
`define LACC_PHASE_B_OFS     10'h100

`define LACC_THRS_SHIFT      5
`define LACC_DN_CNT_W        5
`define LACC_DN_N0           5'h1F
`define LACC_DN_N1           5'h07
`define LACC_DN_N2           5'h01
`define LACC_DN_N3           5'h00

`define LACC_STAT_SCALE_LSB  16
`define LACC_STAT_ACTIVE_BIT 8
`define LACC_DUTY_AUTO_LSB   16
`define LACC_GRAD_LSB        16

`endif

// >>> verilog/lacc_current_reg.v
`timescale 1ns/10ps
`include "lacc_consts.vh"
module lacc_current_reg #(
	parameter CUR_W  = 5,
	parameter LOAD_W = 10
) (
	input  wire              mclk,
	input  wire              rst_b,
	input  wire              enable,
	input  wire              fullstep,
	input  wire [LOAD_W-1:0] load,
	input  wire [CUR_W-1:0]  run_current,
	input  wire [3:0]        lower_thrs,
	input  wire [3:0]        hyst,
	input  wire [1:0]        up_width,
	input  wire [1:0]        dn_speed,
	input  wire              quarter_floor,
	output reg  [CUR_W-1:0]  scale_reg
);
	reg  [CUR_W-1:0]              scale_next;
	reg  [`LACC_DN_CNT_W-1:0]     dn_cnt_reg;
	reg  [`LACC_DN_CNT_W-1:0]     dn_cnt_next;
	reg  [`LACC_DN_CNT_W-1:0]     dn_limit;
	reg  [CUR_W+3:0]              raised;
	wire [CUR_W-1:0]              floor_val;
	wire [LOAD_W+1:0]             lo_lim;
	wire [LOAD_W+1:0]             hi_lim;
	wire                          want_up;
	wire                          want_dn;

	assign floor_val = quarter_floor ? (run_current >> 2) : (run_current >> 1); // RULE_01
	assign lo_lim    = {{(LOAD_W-2){1'b0}}, lower_thrs} << `LACC_THRS_SHIFT;
	assign hi_lim    = ({{(LOAD_W-2){1'b0}}, lower_thrs} + {{(LOAD_W-2){1'b0}}, hyst}
		+ {{(LOAD_W+1){1'b0}}, 1'b1}) << `LACC_THRS_SHIFT;
	assign want_up   = {2'b00, load} < lo_lim; // RULE_06
	assign want_dn   = {2'b00, load} >= hi_lim; // RULE_04

	always @* begin
		case (dn_speed) // RULE_03
		2'b00: dn_limit = `LACC_DN_N0;
		2'b01: dn_limit = `LACC_DN_N1;
		2'b10: dn_limit = `LACC_DN_N2;
		default: dn_limit = `LACC_DN_N3;
		endcase
	end

	always @* begin
		scale_next  = scale_reg;
		dn_cnt_next = dn_cnt_reg;
		raised      = {4'h0, scale_reg} + ({{(CUR_W+3){1'b0}}, 1'b1} << up_width); // RULE_05
		if (!enable) begin
			// Idle regulator tracks full run current so enabling starts from a safe level
			scale_next  = run_current;
			dn_cnt_next = {`LACC_DN_CNT_W{1'b0}};
		end else if (fullstep) begin
			if (want_up) begin
				dn_cnt_next = {`LACC_DN_CNT_W{1'b0}};
				if (raised > {4'h0, run_current})
					scale_next = run_current; // RULE_15
				else
					scale_next = raised[CUR_W-1:0];
			end else if (want_dn) begin
				if (dn_cnt_reg >= dn_limit) begin
					dn_cnt_next = {`LACC_DN_CNT_W{1'b0}};
					if (scale_reg > floor_val)
						scale_next = scale_reg - {{(CUR_W-1){1'b0}}, 1'b1};
				end else begin
					dn_cnt_next = dn_cnt_reg + {{(`LACC_DN_CNT_W-1){1'b0}}, 1'b1};
				end
			end
			// Run current may have moved under us: keep scale inside the window
			if (scale_next > run_current)
				scale_next = run_current; // RULE_15
			else if (scale_next < floor_val)
				scale_next = floor_val; // RULE_15
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			scale_reg  <= {CUR_W{1'b0}};
			dn_cnt_reg <= {`LACC_DN_CNT_W{1'b0}};
		end else begin
			scale_reg  <= scale_next;
			dn_cnt_reg <= dn_cnt_next;
		end
	end
endmodule

// >>> verilog/lacc_top.v
`timescale 1ns/10ps
`include "lacc_consts.vh"
module lacc_top #(
	parameter CUR_W   = 5,
	parameter LOAD_W  = 10,
	parameter INDEX_W = 10
) (
	input  wire                       mclk,
	input  wire                       rst_b,
	input  wire                       reg_wr,
	input  wire                       reg_rd,
	input  wire [`LACC_ADDR_W-1:0]    reg_addr,
	input  wire [31:0]                reg_wdata,
	output reg  [31:0]                reg_rdata,
	output reg                        reg_rvalid,
	input  wire                       fullstep,
	input  wire [LOAD_W-1:0]          load_measurement,
	input  wire [`LACC_VEL_W-1:0]     step_period,
	input  wire [CUR_W-1:0]           run_current,
	input  wire [INDEX_W-1:0]         microstep_index,
	input  wire [7:0]                 duty_scale_sum,
	input  wire [8:0]                 duty_scale_auto,
	input  wire [7:0]                 auto_offset,
	input  wire [7:0]                 auto_gradient,
	output wire [CUR_W-1:0]           current_scale,
	output reg                        adapt_active,
	output reg  [31:0]                chopper_config,
	output reg  [`LACC_VPWM_W-1:0]    voltage_pwm_config,
	output reg  [INDEX_W-1:0]         phase_b_index
);
	reg  [15:0]                adaptive_current_config;
	reg  [`LACC_VEL_W-1:0]     adapt_velocity_threshold;
	reg  [LOAD_W-1:0]          load_result_reg;
	reg  [INDEX_W-1:0]         mstep_reg;
	reg  [16:0]                duty_reg;
	reg  [15:0]                tune_off_grad_reg;
	reg  [31:0]                rdata_next;
	wire [3:0]                 lower_thrs;
	wire [3:0]                 hyst;
	wire [1:0]                 up_width;
	wire [1:0]                 dn_speed;
	wire                       quarter_floor;
	wire                       active_next;

	assign lower_thrs    = adaptive_current_config[`LACC_LOWER_LSB +: 4];
	assign up_width      = adaptive_current_config[`LACC_UPW_LSB +: 2];
	assign hyst          = adaptive_current_config[`LACC_HYST_LSB +: 4];
	assign dn_speed      = adaptive_current_config[`LACC_DNSPD_LSB +: 2];
	assign quarter_floor = adaptive_current_config[`LACC_QFLOOR_BIT];

	// Adaptation runs only at or above the velocity threshold and with a nonzero lower bound
	assign active_next = (lower_thrs != 4'h0) // RULE_07
		&& (adapt_velocity_threshold >= step_period); // RULE_13

	lacc_current_reg #(
		.CUR_W  (CUR_W),
		.LOAD_W (LOAD_W)
	) u_reg (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.enable        (adapt_active),
		.fullstep      (fullstep),
		.load          (load_measurement),
		.run_current   (run_current),
		.lower_thrs    (lower_thrs),
		.hyst          (hyst),
		.up_width      (up_width),
		.dn_speed      (dn_speed),
		.quarter_floor (quarter_floor),
		.scale_reg     (current_scale)
	);

	// Register writes; reserved config bits are masked so stray ones never steer logic
	always @(posedge mclk) begin
		if (!rst_b) begin
			adaptive_current_config  <= `LACC_CONFIG_RESET;
			adapt_velocity_threshold <= {`LACC_VEL_W{1'b0}};
			chopper_config           <= `LACC_CHOP_RESET;
			voltage_pwm_config       <= `LACC_VPWM_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
			`LACC_ADDR_CONFIG:
				adaptive_current_config <= reg_wdata[15:0] & `LACC_CONFIG_MASK;
			`LACC_ADDR_VEL_THRS:
				adapt_velocity_threshold <= reg_wdata[`LACC_VEL_W-1:0];
			`LACC_ADDR_CHOP:
				chopper_config <= reg_wdata;
			`LACC_ADDR_VPWM:
				voltage_pwm_config <= reg_wdata[`LACC_VPWM_W-1:0];
			default: begin
			end
			endcase
		end
	end

	// Readback capture; a fullstep strobe samples the load value once per step
	always @(posedge mclk) begin
		if (!rst_b) begin
			load_result_reg   <= {LOAD_W{1'b0}};
			mstep_reg         <= {INDEX_W{1'b0}};
			phase_b_index     <= {INDEX_W{1'b0}};
			duty_reg          <= 17'h00000;
			tune_off_grad_reg <= 16'h0000;
			adapt_active      <= 1'b0;
		end else begin
			if (fullstep)
				load_result_reg <= load_measurement; // RULE_14
			mstep_reg         <= microstep_index; // RULE_10
			phase_b_index     <= microstep_index + `LACC_PHASE_B_OFS; // RULE_10
			duty_reg          <= {duty_scale_auto, duty_scale_sum}; // RULE_11
			tune_off_grad_reg <= {auto_gradient, auto_offset}; // RULE_12
			adapt_active      <= active_next;
		end
	end

	// Write-only registers and unmapped addresses read back as zero
	always @* begin
		rdata_next = 32'h00000000;
		case (reg_addr)
		`LACC_ADDR_LOAD:
			rdata_next[LOAD_W-1:0] = load_result_reg;
		`LACC_ADDR_MSTEP:
			rdata_next[INDEX_W-1:0] = mstep_reg; // RULE_09
		`LACC_ADDR_CHOP:
			rdata_next = chopper_config;
		`LACC_ADDR_DRVSTAT: begin
			rdata_next[`LACC_STAT_SCALE_LSB +: CUR_W] = current_scale;
			rdata_next[`LACC_STAT_ACTIVE_BIT]          = adapt_active;
		end
		`LACC_ADDR_VPWM:
			rdata_next[`LACC_VPWM_W-1:0] = voltage_pwm_config;
		`LACC_ADDR_DUTY: begin
			rdata_next[7:0] = duty_reg[7:0]; // RULE_11
			rdata_next[`LACC_DUTY_AUTO_LSB +: 9] = duty_reg[16:8];
		end
		`LACC_ADDR_TUNE: begin
			rdata_next[7:0] = tune_off_grad_reg[7:0]; // RULE_12
			rdata_next[`LACC_GRAD_LSB +: 8] = tune_off_grad_reg[15:8]; // RULE_12
		end
		default:
			rdata_next = 32'h00000000;
		endcase
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			reg_rdata  <= 32'h00000000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rdata_next;
		end
	end
endmodule

// >>> tb/lacc_sva.sv
`timescale 1ns/10ps
module lacc_sva #(parameter CUR_W = 5, parameter LOAD_W = 10, parameter INDEX_W = 10) (
	input wire               mclk,
	input wire               rst_b,
	input wire               reg_wr,
	input wire               reg_rd,
	input wire [6:0]         reg_addr,
	input wire [31:0]        reg_wdata,
	input wire [31:0]        reg_rdata,
	input wire               reg_rvalid,
	input wire               fullstep,
	input wire [LOAD_W-1:0]  load_measurement,
	input wire [CUR_W-1:0]   run_current,
	input wire [INDEX_W-1:0] microstep_index,
	input wire [CUR_W-1:0]   current_scale,
	input wire               adapt_active,
	input wire [INDEX_W-1:0] phase_b_index
);
	// Shadow of the write-only config; assumes fullsteps wait a few cycles after a write
	reg  [15:0]      cfg_reg;
	wire [4:0]       hs  = cfg_reg[3:0] + cfg_reg[11:8] + 5'h01;
	wire [10:0]      lo  = {2'h0, cfg_reg[3:0], 5'h00};
	wire [10:0]      hi  = {1'h0, hs, 5'h00};
	wire [10:0]      ld  = {1'h0, load_measurement};
	wire [CUR_W:0]   up  = current_scale + (6'h01 << cfg_reg[6:5]);
	wire [CUR_W-1:0] flr = cfg_reg[15] ? run_current >> 2 : run_current >> 1;
	wire [CUR_W-1:0] upc = (up > run_current) ? run_current : up[CUR_W-1:0];
	wire [CUR_W-1:0] dnc = (current_scale <= flr) ? flr : current_scale - 1'b1;
	always @(posedge mclk) begin
		if (!rst_b)
			cfg_reg <= 16'h0000;
		else if (reg_wr && reg_addr == 7'h42)
			cfg_reg <= reg_wdata[15:0] & 16'hEF6F;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_fs; fullstep && adapt_active; endsequence
	sequence s_rdms; reg_rd && reg_addr == 7'h6A; endsequence
	property p_up; s_fs ##0 (ld < lo) |=> current_scale == $past(upc); endproperty
	property p_neu; s_fs ##0 (ld >= lo && ld < hi) |=> $stable(current_scale); endproperty
	property p_dn; s_fs ##0 (ld >= hi && cfg_reg[14:13] == 2'h3) |=> current_scale == $past(dnc);
	endproperty
	// A floor change only takes hold at the next fullstep, so a fresh config write is skipped
	property p_flr; adapt_active && $stable(run_current) && $stable(cfg_reg)
		|-> current_scale >= flr; endproperty
	property p_ceil; $stable(run_current) |-> current_scale <= run_current; endproperty
	property p_off; $past(rst_b) && !$past(adapt_active) |-> current_scale == $past(run_current);
	endproperty
	property p_rv; $past(rst_b) |-> reg_rvalid == $past(reg_rd); endproperty
	property p_idx; $past(rst_b) |-> phase_b_index == $past(microstep_index) + 10'h100; endproperty
	property p_ms; s_rdms |=> reg_rvalid && reg_rdata == $past(microstep_index, 2); endproperty
	a_up: assert property (p_up) else $error("up step wrong");
	a_neu: assert property (p_neu) else $error("scale moved in window");
	a_dn: assert property (p_dn) else $error("down step wrong");
	a_flr: assert property (p_flr) else $error("scale below floor");
	a_ceil: assert property (p_ceil) else $error("scale above run");
	a_off: assert property (p_off) else $error("inactive scale wrong");
	a_rv: assert property (p_rv) else $error("read valid wrong");
	a_idx: assert property (p_idx) else $error("phase b index wrong");
	a_ms: assert property (p_ms) else $error("index readback wrong");
endmodule
bind lacc_top lacc_sva #(.CUR_W(CUR_W), .LOAD_W(LOAD_W), .INDEX_W(INDEX_W)) i_sva (.mclk, .rst_b,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .fullstep, .load_measurement,
	.run_current, .microstep_index, .current_scale, .adapt_active, .phase_b_index);

// >>> tb/tb_load_adaptive_current_control.sv
`timescale 1ns/10ps
module tb_load_adaptive_current_control;
	reg         mclk = 1'b0;
	reg         rst_b = 1'b0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [6:0]  reg_addr = 7'h00;
	reg  [31:0] reg_wdata = 32'h0;
	reg         fullstep = 1'b0;
	reg  [9:0]  load_measurement = 10'h000;
	reg  [19:0] step_period = 20'h00400;
	reg  [4:0]  run_current = 5'h18;
	reg  [9:0]  microstep_index = 10'h000;
	reg  [7:0]  duty_scale_sum = 8'h00;
	reg  [8:0]  duty_scale_auto = 9'h000;
	reg  [7:0]  auto_offset = 8'h00;
	reg  [7:0]  auto_gradient = 8'h00;
	reg  [31:0] v;
	wire [31:0] reg_rdata;
	wire        reg_rvalid;
	wire [4:0]  current_scale;
	wire        adapt_active;
	wire [31:0] chopper_config;
	wire [21:0] voltage_pwm_config;
	wire [9:0]  phase_b_index;
	integer     n_errors = 0;
	integer     num_checks = 0;
	integer     k, i, lo, hi, up, dn, flr, scale, cnt, act;
	lacc_top i_dut (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.fullstep, .load_measurement, .step_period, .run_current, .microstep_index, .duty_scale_sum,
		.duty_scale_auto, .auto_offset, .auto_gradient, .current_scale, .adapt_active,
		.chopper_config, .voltage_pwm_config, .phase_b_index);
	always #2 mclk = ~mclk;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [6:0] a, input [31:0] d);
		begin
			@(negedge mclk);
			reg_wr = 1'b1;
			reg_addr = a;
			reg_wdata = d;
			@(negedge mclk);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [6:0] a, input [31:0] e);
		begin
			@(negedge mclk);
			reg_rd = 1'b1;
			reg_addr = a;
			@(negedge mclk);
			reg_rd = 1'b0;
			chk(reg_rvalid, 1);
			chk(reg_rdata, e);
		end
	endtask
	task fs(input [9:0] l);
		begin
			@(negedge mclk);
			fullstep = 1'b1;
			load_measurement = l;
			@(negedge mclk);
			fullstep = 1'b0;
			if (act && l < lo) begin
				cnt = 0;
				scale = (scale + up > 24) ? 24 : scale + up;
			end else if (act && l >= hi) begin
				cnt = cnt + 1;
				if (cnt == dn) begin
					cnt = 0;
					scale = (scale - 1 < flr) ? flr : scale - 1;
				end
			end
			chk(current_scale, scale);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		#40000;
		n_errors = n_errors + 1;
		give_verdict;
	end
	initial begin
		v = $urandom(32'h629C);
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		rd(7'h6C, 32'h13008001);
		v = $urandom;
		wr(7'h6C, v);
		rd(7'h6C, v);
		chk(chopper_config, v);
		wr(7'h70, v);
		rd(7'h70, v & 32'h003FFFFF);
		chk(voltage_pwm_config, v & 32'h003FFFFF);
		{microstep_index, duty_scale_sum, auto_offset, auto_gradient} = $urandom;
		duty_scale_auto = $urandom;
		wr(7'h6A, v);
		rd(7'h6A, microstep_index);
		chk(phase_b_index, (microstep_index + 256) % 1024);
		rd(7'h71, {7'h00, duty_scale_auto, 8'h00, duty_scale_sum});
		rd(7'h72, {8'h00, auto_gradient, 8'h00, auto_offset});
		rd(7'h42, 0);
		rd(7'h00, 0);
		wr(7'h14, 32'h00000400);
		for (k = 0; k < 8; k = k + 1) begin
			wr(7'h42, 0);
			repeat (4) @(negedge mclk);
			act = 0;
			chk(current_scale, 24);
			lo = (1 + $urandom % 3);
			hi = (lo + $urandom % 4 + 1) * 32;
			up = 1 << (k % 4);
			dn = (k % 4 == 0) ? 32 : (k % 4 == 1) ? 8 : (k % 4 == 2) ? 2 : 1;
			flr = (k < 4) ? 12 : 6;
			wr(7'h42, (k / 4) * 32768 + (k % 4) * 8192 + (hi / 32 - lo - 1) * 256
				+ (k % 4) * 32 + lo);
			lo = lo * 32;
			repeat (4) @(negedge mclk);
			{act, scale, cnt} = {32'd1, 32'd24, 32'd0};
			chk(adapt_active, 1);
			for (i = 0; i < 40; i = i + 1)
				fs($urandom % 1024);
			v = load_measurement;
			load_measurement = ~load_measurement;
			rd(7'h41, v);
			rd(7'h6F, {11'h000, scale[4:0], 7'h00, 1'b1, 8'h00});
		end
		step_period = 20'h00401;
		repeat (4) @(negedge mclk);
		{act, scale} = {32'd0, 32'd24};
		chk(adapt_active, 0);
		fs(0);
		rd(7'h41, 0);
		give_verdict;
	end
endmodule
